// ==== design/bsc_defines.svh ====
// Purpose: bit positions, reset values and timing counts of the
//          bridge system control register, low half
// Assumes: 32-bit configuration word, bits 15..2 held here
// Notes:   bits 31..16 and 1..0 live elsewhere and read as zero here
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH

// field positions
`define BSC_BIT_DN_BURST 15
`define BSC_BIT_UP_BURST 14
`define BSC_BIT_SEEN     13
`define BSC_BIT_RAIL     12
`define BSC_BIT_STREAM   11
`define BSC_BIT_RISE     10
`define BSC_BIT_FALL     9
`define BSC_BIT_PROBE    8
`define BSC_BIT_RSV_HI   7
`define BSC_BIT_LOWPOW   6
`define BSC_BIT_LOCK     5
`define BSC_BIT_PARITY   4
`define BSC_BIT_DMA      3
`define BSC_BIT_RSV_LO   2

// byte enables covering the upper and lower halves of the low half
`define BSC_BE_HI 1
`define BSC_BE_LO 0

// reset values
`define BSC_RST_DN_BURST 1'b1
`define BSC_RST_UP_BURST 1'b0
`define BSC_RST_LOWPOW   1'b1
`define BSC_RST_LOCK     1'b1
`define BSC_RST_PARITY   1'b0
`define BSC_RST_DMA      1'b0
`define BSC_RST_STATUS   1'b0
`define BSC_RAIL_VALUE   1'b1
`define BSC_RSV_VALUE    1'b0

// settle delays in clock cycles after the switch stream is sent
`define BSC_UP_SETTLE_CYC   16'h0010
`define BSC_DOWN_SETTLE_CYC 16'h0010

`endif

// ==== design/bsc_pkg.sv ====
// Purpose: shared types of the bridge system control block
// Assumes: bsc_defines.svh holds all numbers
// Notes:   structs carry the request and the control outputs
package bsc_pkg;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [1:0]  func;
    logic [3:0]  be;
    logic [31:0] wdata;
  } bsc_req_t;

  typedef struct packed {
    logic down_read_burst_en;
    logic up_read_burst_en;
    logic low_consumption_en;
    logic ident_write_lock;
    logic card_parity_to_syserr;
    logic central_dma_en;
  } bsc_ctrl_t;

  typedef struct packed {
    logic switch_stream_busy;
    logic rise_settle_pending;
    logic fall_settle_pending;
  } bsc_pwr_t;

  typedef enum logic [2:0] {
    PWR_IDLE   = 3'b001,
    PWR_STREAM = 3'b010,
    PWR_SETTLE = 3'b100
  } bsc_pwr_state_t;

endpackage : bsc_pkg

// ==== design/bsc_pwr_track.sv ====
// Purpose: per-socket power switch stream and settle status
// Assumes: change and sent strobes are one-cycle pulses
// Notes:   a new change request during settle restarts the stream
`timescale 1ns/100ps
`include "bsc_defines.svh"

module bsc_pwr_track
  import bsc_pkg::*;
#(
  parameter int unsigned          CNT_W    = 16,
  parameter logic [CNT_W-1:0]     UP_CYC   = `BSC_UP_SETTLE_CYC,
  parameter logic [CNT_W-1:0]     DOWN_CYC = `BSC_DOWN_SETTLE_CYC
) (
  // clock and control
  input  wire logic     clk_in,
  input  wire logic     rst_n_in,
  input  wire logic     ce_in,
  // serializer events
  input  wire logic     change_req_in,
  input  wire logic     rise_in,
  input  wire logic     stream_sent_in,
  // status
  output bsc_pwr_t      status_out
);

  bsc_pwr_state_t   state, next_state;
  logic             rise, next_rise;
  logic [CNT_W-1:0] cnt, next_cnt;

  always_comb begin
    next_state = state;
    next_rise  = rise;
    next_cnt   = cnt;
    case (state)
      PWR_IDLE: begin
        if (change_req_in) begin
          next_state = PWR_STREAM;
          next_rise  = rise_in;
        end
      end
      PWR_STREAM: begin
        if (stream_sent_in) begin
          next_state = PWR_SETTLE;
          next_cnt   = rise ? UP_CYC : DOWN_CYC;
        end
      end
      PWR_SETTLE: begin
        if (change_req_in) begin
          next_state = PWR_STREAM;
          next_rise  = rise_in;
        end else if (cnt <= CNT_W'(1)) begin
          next_state = PWR_IDLE;
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      default: next_state = PWR_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= PWR_IDLE;
      rise  <= 1'b0;
      cnt   <= '0;
    end else if (ce_in) begin
      state <= next_state;
      rise  <= next_rise;
      cnt   <= next_cnt;
    end
  end

  assign status_out.switch_stream_busy  = (state != PWR_IDLE); // R5
  assign status_out.rise_settle_pending = (state == PWR_SETTLE) && rise; // R6
  assign status_out.fall_settle_pending = (state == PWR_SETTLE) && !rise; // R7

  ////////////////////////////////////////////////////////////////////////

  sequence s_req;
    (state == PWR_IDLE) && change_req_in && ce_in;
  endsequence

  sequence s_up_sent;
    (state == PWR_STREAM) && stream_sent_in && rise && ce_in;
  endsequence

  sequence s_down_sent;
    (state == PWR_STREAM) && stream_sent_in && !rise && ce_in;
  endsequence

  property p_req_busy;
    @(posedge clk_in) disable iff (!rst_n_in)
    s_req |=> status_out.switch_stream_busy && !status_out.rise_settle_pending;
  endproperty
  a_req_busy: assert property (p_req_busy) else $error("stream busy missing"); // R5

  property p_up_settle;
    @(posedge clk_in) disable iff (!rst_n_in)
    s_up_sent |=> status_out.rise_settle_pending && status_out.switch_stream_busy;
  endproperty
  a_up_settle: assert property (p_up_settle) else $error("rise settle missing"); // R6

  property p_down_settle;
    @(posedge clk_in) disable iff (!rst_n_in)
    s_down_sent |=> status_out.fall_settle_pending
                    && !status_out.rise_settle_pending;
  endproperty
  a_down_settle: assert property (p_down_settle) else $error("fall settle missing"); // R7

endmodule : bsc_pwr_track

// ==== design/bsc_sysctl.sv ====
// Purpose: low half of the bridge system control register
// Assumes: configuration decode outside selects this word and the
//          function; requests are single-cycle strobes
// Notes:   functions 0 and 1 map to sockets 0 and 1; other
//          functions read zero and their writes are dropped
// Functional notes
// [R1] bit 15 downstream read burst, resets enabled
// [R2] bit 14 upstream read burst, resets disabled
// [R3] bit 13 socket activity, cleared on read
// [R4] bit 12 reads one for functions 0 and 1
// [R5] bit 11 busy while switch stream runs
// [R6] bit 10 set until power-up delay expires
// [R7] bit 9 set until power-down delay expires
// [R8] bit 8 per-socket card interrogation busy
// [R9] bits 7 and 2 read zero
// [R10] bit 6 low power enable, resets one
// [R11] bit 5 locks identity registers, resets one
// [R12] bit 4 forwards card parity to syserr
// [R13] bit 3 central dma enable, resets zero
// [R14] software routes dma request and grant lines
// [R15] software touches global bits via function 0
// [R16] global bits cleared only by global reset
// [R17] writes to status and reserved bits ignored
`timescale 1ns/100ps
`include "bsc_defines.svh"

module bsc_sysctl
  import bsc_pkg::*;
#(
  parameter int unsigned    NUM_SOCK = 2,
  parameter int unsigned    CNT_W    = 16,
  parameter logic [CNT_W-1:0] UP_CYC   = `BSC_UP_SETTLE_CYC,
  parameter logic [CNT_W-1:0] DOWN_CYC = `BSC_DOWN_SETTLE_CYC
) (
  // clock, global reset, clock enable
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  input  wire logic                ce_in,
  // configuration access to this word
  input  bsc_req_t                 req_in,
  output logic [31:0]              rdata_out,
  // per-function reset, leaves global bits alone
  input  wire logic [NUM_SOCK-1:0] func_rst_in,
  // socket events
  input  wire logic [NUM_SOCK-1:0] sock_access_in,
  input  wire logic [NUM_SOCK-1:0] probe_busy_in,
  input  wire logic [NUM_SOCK-1:0] pwr_change_in,
  input  wire logic [NUM_SOCK-1:0] pwr_rise_in,
  input  wire logic [NUM_SOCK-1:0] pwr_sent_in,
  // card-side parity error strobe
  input  wire logic                card_parity_err_in,
  // controls to the rest of the bridge
  output bsc_ctrl_t                ctrl_out,
  output logic                     syserr_req_out
);

  ////////////////////////////////////////////////////////////////////////
  // access decode

  function automatic logic sock_hit(input logic [1:0] func,
                                    input int unsigned s);
    sock_hit = (func == 2'(s));
  endfunction : sock_hit

  logic func_ok;
  logic wr_ok;

  assign func_ok = (32'(req_in.func) < NUM_SOCK);
  assign wr_ok   = req_in.wr && func_ok;

  ////////////////////////////////////////////////////////////////////////
  // global control bits
  // shared by both functions; only the global reset touches them, so
  // a function reset of one socket cannot disturb the other socket

  bsc_ctrl_t ctrl, next_ctrl;

  always_comb begin
    next_ctrl = ctrl;
    if (wr_ok && req_in.be[`BSC_BE_HI]) begin
      next_ctrl.down_read_burst_en = req_in.wdata[`BSC_BIT_DN_BURST]; // R1
      next_ctrl.up_read_burst_en   = req_in.wdata[`BSC_BIT_UP_BURST]; // R2
    end
    if (wr_ok && req_in.be[`BSC_BE_LO]) begin
      next_ctrl.low_consumption_en    = req_in.wdata[`BSC_BIT_LOWPOW]; // R10
      next_ctrl.ident_write_lock      = req_in.wdata[`BSC_BIT_LOCK]; // R11
      next_ctrl.card_parity_to_syserr = req_in.wdata[`BSC_BIT_PARITY]; // R12
      next_ctrl.central_dma_en        = req_in.wdata[`BSC_BIT_DMA]; // R13
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin // R16
      ctrl.down_read_burst_en    <= `BSC_RST_DN_BURST; // R1
      ctrl.up_read_burst_en      <= `BSC_RST_UP_BURST; // R2
      ctrl.low_consumption_en    <= `BSC_RST_LOWPOW; // R10
      ctrl.ident_write_lock      <= `BSC_RST_LOCK; // R11
      ctrl.card_parity_to_syserr <= `BSC_RST_PARITY; // R12
      ctrl.central_dma_en        <= `BSC_RST_DMA; // R13
    end else if (ce_in) begin
      ctrl <= next_ctrl;
    end
  end

  assign ctrl_out = ctrl;

  ////////////////////////////////////////////////////////////////////////
  // per-socket status
  // status bits take no write data at all, so writes cannot touch them

  logic [NUM_SOCK-1:0] seen, next_seen;
  logic [NUM_SOCK-1:0] probe, next_probe;

  always_comb begin
    next_seen  = seen; // R17
    next_probe = probe;
    for (int unsigned s = 0; s < NUM_SOCK; s++) begin
      if (func_rst_in[s]) begin
        next_seen[s]  = `BSC_RST_STATUS;
        next_probe[s] = `BSC_RST_STATUS;
      end else begin
        // clear on read first, so a same-cycle access still sets it
        if (req_in.rd && sock_hit(req_in.func, s)) begin
          next_seen[s] = 1'b0; // R3
        end
        if (sock_access_in[s]) begin
          next_seen[s] = 1'b1; // R3
        end
        next_probe[s] = probe_busy_in[s]; // R8
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      seen  <= '0;
      probe <= '0;
    end else if (ce_in) begin
      seen  <= next_seen;
      probe <= next_probe;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power switch stream trackers

  bsc_pwr_t pwr [NUM_SOCK];

  for (genvar g = 0; g < NUM_SOCK; g++) begin : g_pwr
    bsc_pwr_track #(
      .CNT_W    (CNT_W),
      .UP_CYC   (UP_CYC),
      .DOWN_CYC (DOWN_CYC)
    ) u_pwr (
      .clk_in         (clk_in),
      .rst_n_in       (rst_n_in),
      .ce_in          (ce_in),
      .change_req_in  (pwr_change_in[g]),
      .rise_in        (pwr_rise_in[g]),
      .stream_sent_in (pwr_sent_in[g]),
      .status_out     (pwr[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // read path
  // data is registered and held until the next read; the value seen
  // is the one before the read-clear takes effect

  logic [31:0] rdata, next_rdata;

  always_comb begin
    next_rdata = rdata;
    if (req_in.rd) begin
      next_rdata = 32'h0000_0000;
      if (func_ok) begin
        next_rdata[`BSC_BIT_DN_BURST] = ctrl.down_read_burst_en;
        next_rdata[`BSC_BIT_UP_BURST] = ctrl.up_read_burst_en;
        next_rdata[`BSC_BIT_RAIL]     = `BSC_RAIL_VALUE; // R4
        next_rdata[`BSC_BIT_RSV_HI]   = `BSC_RSV_VALUE; // R9
        next_rdata[`BSC_BIT_LOWPOW]   = ctrl.low_consumption_en;
        next_rdata[`BSC_BIT_LOCK]     = ctrl.ident_write_lock;
        next_rdata[`BSC_BIT_PARITY]   = ctrl.card_parity_to_syserr;
        next_rdata[`BSC_BIT_DMA]      = ctrl.central_dma_en;
        next_rdata[`BSC_BIT_RSV_LO]   = `BSC_RSV_VALUE; // R9
      end
      for (int unsigned s = 0; s < NUM_SOCK; s++) begin
        if (sock_hit(req_in.func, s)) begin
          next_rdata[`BSC_BIT_SEEN]   = seen[s]; // R3
          next_rdata[`BSC_BIT_STREAM] = pwr[s].switch_stream_busy; // R5
          next_rdata[`BSC_BIT_RISE]   = pwr[s].rise_settle_pending; // R6
          next_rdata[`BSC_BIT_FALL]   = pwr[s].fall_settle_pending; // R7
          next_rdata[`BSC_BIT_PROBE]  = probe[s]; // R8
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata <= 32'h0000_0000;
    end else if (ce_in) begin
      rdata <= next_rdata;
    end
  end

  assign rdata_out = rdata;

  ////////////////////////////////////////////////////////////////////////
  // parity forwarding
  // one registered cycle of latency keeps syserr glitch free

  logic syserr, next_syserr;

  always_comb begin
    next_syserr = card_parity_err_in && ctrl.card_parity_to_syserr; // R12
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      syserr <= 1'b0;
    end else if (ce_in) begin
      syserr <= next_syserr;
    end
  end

  assign syserr_req_out = syserr;

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_wr_hi;
    ce_in && wr_ok && req_in.be[`BSC_BE_HI];
  endsequence

  property p_reset_vals;
    @(posedge clk_in)
    !rst_n_in |=> ctrl.down_read_burst_en && !ctrl.up_read_burst_en
                  && ctrl.low_consumption_en && ctrl.ident_write_lock
                  && !ctrl.card_parity_to_syserr && !ctrl.central_dma_en;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value"); // R16

  property p_dn_write;
    @(posedge clk_in) disable iff (!rst_n_in)
    s_wr_hi |=> ctrl.down_read_burst_en == $past(req_in.wdata[`BSC_BIT_DN_BURST])
                && ctrl.up_read_burst_en == $past(req_in.wdata[`BSC_BIT_UP_BURST]);
  endproperty
  a_dn_write: assert property (p_dn_write) else $error("burst write lost"); // R1

  property p_lane_guard;
    @(posedge clk_in) disable iff (!rst_n_in)
    !(wr_ok && req_in.be[`BSC_BE_HI]) |=> $stable(ctrl.up_read_burst_en);
  endproperty
  a_lane_guard: assert property (p_lane_guard) else $error("burst bit moved"); // R2

  property p_func_rst_keep;
    @(posedge clk_in) disable iff (!rst_n_in)
    (func_rst_in != '0) && !wr_ok |=> $stable(ctrl);
  endproperty
  a_func_rst_keep: assert property (p_func_rst_keep) else $error("global bit lost"); // R16

  property p_read_clear;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && req_in.rd && (req_in.func == 2'h0) && !sock_access_in[0]
      |=> !seen[0];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("activity not cleared"); // R3

  property p_set_wins;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && sock_access_in[0] && !func_rst_in[0] |=> seen[0] ##1 1'b1;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("activity event lost"); // R3

  property p_fixed_bits;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && req_in.rd && func_ok
      |=> rdata_out[`BSC_BIT_RAIL] && !rdata_out[`BSC_BIT_RSV_HI]
          && !rdata_out[`BSC_BIT_RSV_LO];
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("fixed bit wrong"); // R9

  property p_syserr;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in |=> syserr_req_out == ($past(card_parity_err_in)
                                 && $past(ctrl.card_parity_to_syserr));
  endproperty
  a_syserr: assert property (p_syserr) else $error("syserr mismatch"); // R12

  property p_status_ro;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && wr_ok && !req_in.rd && (sock_access_in == '0)
      && (func_rst_in == '0) |=> $stable(seen);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status took write"); // R17

  property p_probe_copy;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && !func_rst_in[0] |=> probe[0] == $past(probe_busy_in[0]);
  endproperty
  a_probe_copy: assert property (p_probe_copy) else $error("probe status lag wrong"); // R8

endmodule : bsc_sysctl

// ==== testbench/bsc_switch_model.sv ====
// Purpose: behavioural power switch serializer for each socket
// Assumes: go_in is a one-cycle pulse, ignored while a frame runs
// Notes:   socket s takes GAP+3*s cycles, so one answers fast, one slow
`timescale 1ns/100ps

module bsc_switch_model #(
  parameter int unsigned NUM_SOCK = 2,
  parameter int unsigned GAP      = 4
) (
  // clock and reset
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  // commands from the bench
  input  wire logic [NUM_SOCK-1:0] go_in,
  input  wire logic [NUM_SOCK-1:0] dir_in,
  // events toward the block
  output logic      [NUM_SOCK-1:0] change_out,
  output logic      [NUM_SOCK-1:0] rise_out,
  output logic      [NUM_SOCK-1:0] sent_out
);
  int cnt [NUM_SOCK];

  ////////////////////////////////////////////////////////////////////
  always @(posedge clk_in) begin
    for (int s = 0; s < NUM_SOCK; s++) begin
      change_out[s] <= 1'b0;
      sent_out[s]   <= 1'b0;
      // direction is only meaningful with change, so it wanders otherwise
      rise_out[s]   <= ~rise_out[s];
      if (!rst_n_in) begin
        cnt[s] <= 0;
      end else if (go_in[s] && cnt[s] == 0) begin
        change_out[s] <= 1'b1;
        rise_out[s]   <= dir_in[s];
        cnt[s]        <= GAP + 3 * s;
      end else if (cnt[s] > 1) begin
        cnt[s] <= cnt[s] - 1;
      end else if (cnt[s] == 1) begin
        sent_out[s] <= 1'b1;
        cnt[s]      <= 0;
      end
    end
  end
endmodule : bsc_switch_model

// ==== testbench/tb_bsc_sysctl.sv ====
// Purpose: self-checking bench of the system control low half
// Assumes: settle counts shortened to 4 cycles
// Notes:   func 1 reads the shared global bits like func 0
`timescale 1ns/100ps

module tb_bsc_sysctl
  import bsc_pkg::*;
();
  localparam int unsigned NS = 2;
  logic          clk_in;
  logic          rst_n_in;
  logic          ce_in;
  bsc_req_t      req_in;
  logic [31:0]   rdata_out;
  logic [NS-1:0] func_rst_in;
  logic [NS-1:0] sock_access_in;
  logic [NS-1:0] probe_busy_in;
  logic [NS-1:0] go;
  logic [NS-1:0] dir;
  logic [NS-1:0] chg;
  logic [NS-1:0] rise;
  logic [NS-1:0] sent;
  logic          card_parity_err_in;
  logic          syserr_req_out;
  bsc_ctrl_t     ctrl_out;
  logic [31:0]   rv;
  int            miscompares;
  int            checks_done;

  ////////////////////////////////////////////////////////////////////
  bsc_sysctl #(.NUM_SOCK(NS), .CNT_W(16), .UP_CYC(16'h0004), .DOWN_CYC(16'h0004)) dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .req_in(req_in),
    .rdata_out(rdata_out), .func_rst_in(func_rst_in), .sock_access_in(sock_access_in),
    .probe_busy_in(probe_busy_in), .pwr_change_in(chg), .pwr_rise_in(rise),
    .pwr_sent_in(sent), .card_parity_err_in(card_parity_err_in),
    .ctrl_out(ctrl_out), .syserr_req_out(syserr_req_out));

  bsc_switch_model #(.NUM_SOCK(NS), .GAP(4)) sw_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .go_in(go), .dir_in(dir),
    .change_out(chg), .rise_out(rise), .sent_out(sent));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  task automatic wr(input logic [1:0] f, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk_in);
    req_in.wr    <= 1'b1;
    req_in.func  <= f;
    req_in.be    <= be;
    req_in.wdata <= d;
    @(posedge clk_in);
    req_in.wr    <= 1'b0;
    req_in.wdata <= ~d;
    @(posedge clk_in);
  endtask : wr

  task automatic rd(input logic [1:0] f, output logic [31:0] v);
    @(posedge clk_in);
    req_in.rd   <= 1'b1;
    req_in.func <= f;
    @(posedge clk_in);
    req_in.rd <= 1'b0;
    #1;
    v = rdata_out;
  endtask : rd

  task automatic par(input logic exp);
    @(posedge clk_in);
    card_parity_err_in <= 1'b1;
    @(posedge clk_in);
    card_parity_err_in <= 1'b0;
    #1;
    chk({31'h0, syserr_req_out}, {31'h0, exp});
    @(posedge clk_in);
    #1;
    chk({31'h0, syserr_req_out}, 32'h0);
  endtask : par

  // polls the status for 24 reads, long enough to outlast the frame and its settle window
  task automatic pwr_run(input int s, input logic d);
    logic [31:0] v;
    bit          s_str;
    bit          s_set;
    bit          bad;
    s_str = 0;
    s_set = 0;
    bad   = 0;
    @(posedge clk_in);
    go[s]  <= 1'b1;
    dir[s] <= d;
    @(posedge clk_in);
    go[s] <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      rd(s[1:0], v);
      if (v[11] === 1'b1 && v[10] === 1'b0 && v[9] === 1'b0) s_str = 1;
      if (v[11] === 1'b1 && v[d ? 10 : 9] === 1'b1) s_set = 1;
      if (v[d ? 9 : 10] !== 1'b0) bad = 1;
    end
    chk({31'h0, s_str}, 32'h1);
    chk({31'h0, s_set}, 32'h1);
    chk({31'h0, bad}, 32'h0);
    chk(v & 32'h0000_0e00, 32'h0);
  endtask : pwr_run

  ////////////////////////////////////////////////////////////////////
  initial begin
    miscompares = 0;
    checks_done = 0;
    rst_n_in = 1'b0;
    ce_in = 1'b1;
    req_in = '0;
    func_rst_in = '0;
    sock_access_in = '0;
    probe_busy_in = '0;
    go = '0;
    dir = '0;
    card_parity_err_in = 1'b0;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(2'h0, rv);
    chk(rv, 32'h0000_9060);
    chk({26'h0, ctrl_out}, 32'h0000_002c);
    rd(2'h2, rv);
    chk(rv, 32'h0);
    wr(2'h0, 4'hf, 32'hffff_ffff);
    rd(2'h0, rv);
    chk(rv, 32'h0000_d078);
    // central dma on; routing its request and grant lines is software's job
    chk({26'h0, ctrl_out}, 32'h0000_003f);
    wr(2'h0, 4'h2, 32'h0);
    rd(2'h0, rv);
    chk(rv, 32'h0000_1078);
    wr(2'h0, 4'h1, 32'h0);
    rd(2'h0, rv);
    chk(rv, 32'h0000_1000);
    wr(2'h0, 4'hf, 32'h0000_4010);
    chk({26'h0, ctrl_out}, 32'h0000_0012);
    wr(2'h2, 4'hf, 32'hffff_ffff);
    rd(2'h0, rv);
    chk(rv, 32'h0000_5010);
    @(posedge clk_in);
    ce_in <= 1'b0;
    wr(2'h0, 4'hf, 32'h0);
    @(posedge clk_in);
    ce_in <= 1'b1;
    rd(2'h0, rv);
    chk(rv, 32'h0000_5010);
    par(1'b1);
    wr(2'h0, 4'h1, 32'h0);
    par(1'b0);
    @(posedge clk_in);
    func_rst_in <= 2'b11;
    repeat (3) @(posedge clk_in);
    func_rst_in <= 2'b00;
    rd(2'h0, rv);
    chk(rv, 32'h0000_5000);
    @(posedge clk_in);
    sock_access_in <= 2'b10;
    @(posedge clk_in);
    sock_access_in <= 2'b00;
    rd(2'h0, rv);
    chk(rv, 32'h0000_5000);
    rd(2'h1, rv);
    chk(rv, 32'h0000_7000);
    rd(2'h1, rv);
    chk(rv, 32'h0000_5000);
    // access and read-clear in one cycle: the read sees the old flag, the set wins
    @(posedge clk_in);
    sock_access_in <= 2'b01;
    req_in.rd      <= 1'b1;
    req_in.func    <= 2'h0;
    @(posedge clk_in);
    sock_access_in <= 2'b00;
    req_in.rd      <= 1'b0;
    #1;
    chk(rdata_out, 32'h0000_5000);
    rd(2'h0, rv);
    chk(rv, 32'h0000_7000);
    rd(2'h0, rv);
    chk(rv, 32'h0000_5000);
    @(posedge clk_in);
    probe_busy_in <= 2'b01;
    repeat (2) @(posedge clk_in);
    rd(2'h0, rv);
    chk(rv, 32'h0000_5100);
    rd(2'h1, rv);
    chk(rv, 32'h0000_5000);
    @(posedge clk_in);
    probe_busy_in <= 2'b00;
    repeat (2) @(posedge clk_in);
    rd(2'h0, rv);
    chk(rv, 32'h0000_5000);
    for (int s = 0; s < NS; s++) begin
      pwr_run(s, 1'b1);
      pwr_run(s, 1'b0);
    end
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(2'h0, rv);
    chk(rv, 32'h0000_9060);
    report_and_stop();
  end

  // the whole sequence needs well under 1000 cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    report_and_stop();
  end
endmodule : tb_bsc_sysctl
